//--- verilog/exd_map.vh
// Constants for the extended instruction decoder: quarter phases,
// opcode fields, address masks and reset values.
// Assumes inclusion by bare name from the decoder design files.
`ifndef EXD_MAP_VH
`define EXD_MAP_VH

// Quarter phase bit positions in the one-hot phase register
`define EXD_Q1 0
`define EXD_Q2 1
`define EXD_Q3 2
`define EXD_Q4 3
`define EXD_Q_RST 4'h1

// Opcode fields of the extension group (first nibble 1110)
`define EXD_GRP_EXT 4'he
`define EXD_SUB_ADDU 4'h8
`define EXD_SUB_SUBU 4'h9
`define EXD_SUB_PUSH 4'ha
`define EXD_SUB_MOVS 4'hb
`define EXD_PTR2_SEL 2'h3
`define EXD_GRP_TAIL 4'hf
`define EXD_LONG_MOVE 16'h0002

// Standard exclusive-OR-with-file opcode, bits 15..10
`define EXD_XOR_OPC 6'h06

// Indexed literal offset window and bank control
`define EXD_LOFS_MAX 8'h5f
`define EXD_LOW4K_MASK 14'h0fff
`define EXD_ACC_LO_BANK 6'h00
`define EXD_ACC_HI_BANK 6'h3f

// Widths and reset values
`define EXD_AW 14
`define EXD_ZERO_ADDR 14'h0000
`define EXD_ZERO_BYTE 8'h00
`define EXD_ZERO_WORD 16'h0000

`endif

//--- verilog/exd_opnd_hold.v
// Holds the trailing words of a multi-word move for later cycles.
// Assumes writes come from the decoder on clk_sys; outputs registered.
`timescale 1ns/1ps
`default_nettype none
`include "exd_map.vh"

module exd_opnd_hold #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Capture side
  input wire hold_we,
  input wire hold_sel,
  input wire [WIDTH-1:0] hold_data,
  // Held words
  output reg [WIDTH-1:0] word2_q,
  output reg [WIDTH-1:0] word3_q
);

  ////////////////////////////////////////////////////////////////////
  // Two slots; select low picks the second word, high the third
  always @(posedge clk_sys) begin
    if (rst) begin
      word2_q <= {WIDTH{1'b0}};
      word3_q <= {WIDTH{1'b0}};
    end else if (hold_we) begin
      if (hold_sel) begin
        word3_q <= hold_data;
      end else begin
        word2_q <= hold_data;
      end
    end
  end

endmodule
`default_nettype wire

//--- verilog/exd_decode.v
// Extended instruction decode and execute for an 8-bit CPU core.
// Assumes one fetched word per instruction cycle, offered at Q1, and a
// data memory that returns read data one clk_sys after the request.
`timescale 1ns/1ps
`default_nettype none
`include "exd_map.vh"

// Functional notes
// - Exclusive-OR-with-file: decode Q1, read file Q2, write result Q4.
// - Extension is off after reset; only the set fuse enables it.
// - With extension on, access-bank standard byte ops at file 00..5f use indexed literal offsets.
// - Pointer-two add and subtract forms return after their arithmetic.
// - 1110 1000 11k: add to pointer two and return, 2 cycles, no flags.
// - 1110 1001 11k: subtract from pointer two and return, 2 cycles.
// - 1110 1010 k: store literal at pointer two, decrement, one cycle.
// - 1110 1011 0 plus 1111 word: indexed-to-file move, two cycles.
// - 1110 1011 1 plus 1111 word: indexed-to-indexed move, two cycles.
// - Word 0002 plus two 1111 words: long move, three cycles.
// - Add form adds 0..63 to pointer two, pops PC, then a NOP cycle.
// - Indexed-to-file source is pointer two plus offset; dest literal.
// - Twelve-bit indexed moves force the top two bank bits to zero.
// - A lone trailing word of a multi-word op executes as a NOP.
module exd_decode (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Configuration fuse pin
  input wire ext_set_enable_fuse,
  // Instruction fetch
  input wire fetch_valid,
  input wire [15:0] fetch_word,
  // Core state
  input wire [`EXD_AW-1:0] pointer_two,
  input wire [5:0] bank_sel,
  input wire [7:0] w_reg,
  // Data memory
  output reg dm_rd_en,
  output reg [`EXD_AW-1:0] dm_rd_addr,
  input wire [7:0] dm_rd_data,
  output reg dm_wr_en,
  output reg [`EXD_AW-1:0] dm_wr_addr,
  output reg [7:0] dm_wr_data,
  // Core write-backs
  output reg w_wr_en,
  output reg [7:0] w_wr_data,
  output reg ptr2_wr_en,
  output reg [`EXD_AW-1:0] ptr2_wr_data,
  output reg flag_wr_en,
  output reg flag_n,
  output reg flag_z,
  output reg pc_pop_stack,
  // Cycle status
  output reg std_pass,
  output reg lit_ofs_mode,
  output reg [`EXD_AW-1:0] lit_ofs_addr,
  output reg nop_cycle,
  output wire ext_active
);

  ////////////////////////////////////////////////////////////////////
  // States and operation selectors, all one-hot
  localparam ST_IDLE = 4'b0001;
  localparam ST_WORD2 = 4'b0010;
  localparam ST_WORD3 = 4'b0100;
  localparam ST_NOPC = 4'b1000;

  localparam OP_NONE = 8'b0000_0001;
  localparam OP_XOR = 8'b0000_0010;
  localparam OP_ADDU = 8'b0000_0100;
  localparam OP_SUBU = 8'b0000_1000;
  localparam OP_PUSH = 8'b0001_0000;
  localparam OP_MSF = 8'b0010_0000;
  localparam OP_MSS = 8'b0100_0000;
  localparam OP_MSFL = 8'b1000_0000;

  ////////////////////////////////////////////////////////////////////
  // Helper functions

  // Pointer plus unsigned offset, wrapping in the address width
  function [`EXD_AW-1:0] ptr_add;
    input [`EXD_AW-1:0] base;
    input [7:0] ofs;
    begin
      ptr_add = base + {6'h00, ofs};
    end
  endfunction

  // Keep an address inside the lower four kilobytes
  function [`EXD_AW-1:0] low4k;
    input [`EXD_AW-1:0] addr;
    begin
      low4k = addr & `EXD_LOW4K_MASK;
    end
  endfunction

  // Byte-oriented standard op with access bank and small file address
  function lofs_hit;
    input [15:0] w;
    reg byte_op;
    begin
      byte_op = ((w[15:12] != 4'h0) && (w[15:12] < 4'hc)) ||
                ((w[15:12] == 4'h0) && (w[11:9] == 3'h1));
      lofs_hit = byte_op && !w[8] && (w[7:0] <= `EXD_LOFS_MAX);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg [3:0] q_ff;
  reg fuse_s1_ff;
  reg fuse_s2_ff;
  reg ext_on_ff;
  reg [3:0] state_ff;
  reg [7:0] op_ff;
  reg exec_ff;
  reg [15:0] ir_ff;
  reg [`EXD_AW-1:0] src_ff;
  reg [`EXD_AW-1:0] nxt_src;
  reg [7:0] nxt_op;
  reg [3:0] nxt_state;
  reg nxt_exec;
  reg nxt_pass;
  reg nxt_nop;
  reg hold_we;
  reg hold_sel;
  wire [15:0] word2_q;
  wire [15:0] word3_q;
  wire q1;
  wire [`EXD_AW-1:0] xor_addr;

  assign q1 = q_ff[`EXD_Q1] && fetch_valid;
  assign ext_active = ext_on_ff;

  ////////////////////////////////////////////////////////////////////
  // Quarter phase ring; each clk_sys is one quarter of a cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      q_ff <= `EXD_Q_RST;
    end else begin
      q_ff <= {q_ff[2:0], q_ff[3]};
    end
  end

  // Fuse pin synchroniser; enable only taken at cycle boundaries
  always @(posedge clk_sys) begin
    if (rst) begin
      fuse_s1_ff <= 1'b0;
      fuse_s2_ff <= 1'b0;
      ext_on_ff <= 1'b0;
    end else begin
      fuse_s1_ff <= ext_set_enable_fuse;
      fuse_s2_ff <= fuse_s1_ff;
      if (q_ff[`EXD_Q4]) begin
        ext_on_ff <= fuse_s2_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q1 decode: choose the operation and the next sequence state
  always @* begin
    nxt_op = OP_NONE;
    nxt_state = ST_IDLE;
    nxt_exec = 1'b0;
    nxt_pass = 1'b0;
    nxt_nop = 1'b0;
    hold_we = 1'b0;
    hold_sel = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_exec = 1'b1;
        if (fetch_word[15:10] == `EXD_XOR_OPC) begin
          nxt_op = OP_XOR;
        end else if (ext_on_ff && fetch_word[15:12] == `EXD_GRP_EXT &&
                     fetch_word[11:8] == `EXD_SUB_ADDU &&
                     fetch_word[7:6] == `EXD_PTR2_SEL) begin
          nxt_op = OP_ADDU;
        end else if (ext_on_ff && fetch_word[15:12] == `EXD_GRP_EXT &&
                     fetch_word[11:8] == `EXD_SUB_SUBU &&
                     fetch_word[7:6] == `EXD_PTR2_SEL) begin
          nxt_op = OP_SUBU;
        end else if (ext_on_ff && fetch_word[15:12] == `EXD_GRP_EXT &&
                     fetch_word[11:8] == `EXD_SUB_PUSH) begin
          nxt_op = OP_PUSH;
        end else if (ext_on_ff && fetch_word[15:12] == `EXD_GRP_EXT &&
                     fetch_word[11:8] == `EXD_SUB_MOVS) begin
          // First word only records the source offset
          nxt_op = fetch_word[7] ? OP_MSS : OP_MSF;
          nxt_state = ST_WORD2;
          nxt_exec = 1'b0;
          nxt_nop = 1'b1;
        end else if (ext_on_ff && fetch_word == `EXD_LONG_MOVE) begin
          nxt_op = OP_MSFL;
          nxt_state = ST_WORD2;
          nxt_exec = 1'b0;
          nxt_nop = 1'b1;
        end else if (fetch_word[15:12] == `EXD_GRP_TAIL) begin
          nxt_exec = 1'b0;
          nxt_nop = 1'b1;
        end else begin
          nxt_exec = 1'b0;
          nxt_pass = 1'b1;
        end
      end
      ST_WORD2: begin
        nxt_op = op_ff;
        hold_we = 1'b1;
        if (op_ff == OP_MSFL) begin
          nxt_state = ST_WORD3;
          nxt_nop = 1'b1;
        end else begin
          nxt_exec = 1'b1;
        end
      end
      ST_WORD3: begin
        nxt_op = op_ff;
        hold_we = 1'b1;
        hold_sel = 1'b1;
        nxt_exec = 1'b1;
      end
      ST_NOPC: begin
        nxt_nop = 1'b1;
      end
      default: begin
        nxt_nop = 1'b1;
      end
    endcase
  end

  exd_opnd_hold #(
    .WIDTH(16)
  ) u_hold (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold_we(q1 && hold_we),
    .hold_sel(hold_sel),
    .hold_data(fetch_word),
    .word2_q(word2_q),
    .word3_q(word3_q)
  );

  ////////////////////////////////////////////////////////////////////
  // Exclusive-OR source address, with literal offset when enabled
  assign xor_addr = (ext_on_ff && lofs_hit(fetch_word)) ?
                    ptr_add(pointer_two, fetch_word[7:0]) :
                    fetch_word[8] ? {bank_sel, fetch_word[7:0]} :
                    (fetch_word[7:0] <= `EXD_LOFS_MAX) ?
                    {`EXD_ACC_LO_BANK, fetch_word[7:0]} :
                    {`EXD_ACC_HI_BANK, fetch_word[7:0]};

  // Source address of the read that follows in Q2
  always @* begin
    if (nxt_op == OP_XOR) begin
      nxt_src = xor_addr;
    end else if (nxt_op == OP_MSFL) begin
      nxt_src = ptr_add(pointer_two, {1'b0, word2_q[8:2]});
    end else begin
      nxt_src = low4k(ptr_add(pointer_two,
                              {1'b0, ir_ff[6:0]}));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q1 edge: sequence state, opcode latch and read request setup
  always @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      exec_ff <= 1'b0;
      ir_ff <= `EXD_ZERO_WORD;
      std_pass <= 1'b0;
      nop_cycle <= 1'b0;
      lit_ofs_mode <= 1'b0;
      lit_ofs_addr <= `EXD_ZERO_ADDR;
      src_ff <= `EXD_ZERO_ADDR;
    end else if (q1) begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      exec_ff <= nxt_exec;
      std_pass <= nxt_pass;
      nop_cycle <= nxt_nop;
      if (state_ff == ST_IDLE) begin
        ir_ff <= fetch_word;
      end
      // Literal offset only offered to standard instructions
      lit_ofs_mode <= nxt_pass && ext_on_ff &&
                      lofs_hit(fetch_word);
      lit_ofs_addr <= ptr_add(pointer_two, fetch_word[7:0]);
      src_ff <= nxt_src;
    end else if (q_ff[`EXD_Q1]) begin
      // No word this cycle, so the last operation must not run again
      exec_ff <= 1'b0;
    end else if (q_ff[`EXD_Q4]) begin
      // Returns retire into a forced NOP cycle
      if (exec_ff && (op_ff == OP_ADDU || op_ff == OP_SUBU)) begin
        state_ff <= ST_NOPC;
      end else if (state_ff == ST_NOPC) begin
        state_ff <= ST_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q2 read strobe; the address stands with it, since the memory
  // samples both together at the end of Q2
  always @(posedge clk_sys) begin
    if (rst) begin
      dm_rd_en <= 1'b0;
      dm_rd_addr <= `EXD_ZERO_ADDR;
    end else begin
      dm_rd_en <= q1 && nxt_exec &&
                  (nxt_op == OP_XOR || nxt_op == OP_MSF ||
                   nxt_op == OP_MSS || nxt_op == OP_MSFL);
      if (q1) begin
        dm_rd_addr <= nxt_src;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Q4 write-backs, set up on the Q3 edge so they stand during Q4.
  // Extended ops never raise flag_wr_en, so status stays untouched.
  always @(posedge clk_sys) begin
    if (rst) begin
      dm_wr_en <= 1'b0;
      dm_wr_addr <= `EXD_ZERO_ADDR;
      dm_wr_data <= `EXD_ZERO_BYTE;
      w_wr_en <= 1'b0;
      w_wr_data <= `EXD_ZERO_BYTE;
      ptr2_wr_en <= 1'b0;
      ptr2_wr_data <= `EXD_ZERO_ADDR;
      flag_wr_en <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      pc_pop_stack <= 1'b0;
    end else if (q_ff[`EXD_Q3] && exec_ff) begin
      case (op_ff)
        OP_XOR: begin
          // Destination bit picks W or the file register
          dm_wr_en <= ir_ff[9];
          dm_wr_addr <= src_ff;
          dm_wr_data <= w_reg ^ dm_rd_data;
          w_wr_en <= !ir_ff[9];
          w_wr_data <= w_reg ^ dm_rd_data;
          flag_wr_en <= 1'b1;
          flag_n <= dm_rd_data[7] ^ w_reg[7];
          flag_z <= (w_reg ^ dm_rd_data) == `EXD_ZERO_BYTE;
        end
        OP_ADDU: begin
          ptr2_wr_en <= 1'b1;
          ptr2_wr_data <= ptr_add(pointer_two,
                                  {2'h0, ir_ff[5:0]});
          pc_pop_stack <= 1'b1;
        end
        OP_SUBU: begin
          ptr2_wr_en <= 1'b1;
          ptr2_wr_data <= pointer_two -
                          {8'h00, ir_ff[5:0]};
          pc_pop_stack <= 1'b1;
        end
        OP_PUSH: begin
          dm_wr_en <= 1'b1;
          dm_wr_addr <= pointer_two;
          dm_wr_data <= ir_ff[7:0];
          ptr2_wr_en <= 1'b1;
          ptr2_wr_data <= pointer_two - {{(`EXD_AW-1){1'b0}}, 1'b1};
        end
        OP_MSF: begin
          dm_wr_en <= 1'b1;
          dm_wr_addr <= low4k({2'h0, word2_q[11:0]});
          dm_wr_data <= dm_rd_data;
        end
        OP_MSS: begin
          dm_wr_en <= 1'b1;
          dm_wr_addr <= low4k(ptr_add(pointer_two,
                                      {1'b0, word2_q[6:0]}));
          dm_wr_data <= dm_rd_data;
        end
        OP_MSFL: begin
          dm_wr_en <= 1'b1;
          dm_wr_addr <= {word2_q[1:0], word3_q[11:0]};
          dm_wr_data <= dm_rd_data;
        end
        default: begin
          dm_wr_en <= 1'b0;
        end
      endcase
    end else begin
      // Strobes last exactly the Q4 quarter
      dm_wr_en <= 1'b0;
      w_wr_en <= 1'b0;
      ptr2_wr_en <= 1'b0;
      flag_wr_en <= 1'b0;
      pc_pop_stack <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- dv/exd_checker.sv
// Checker for the extended decoder: quarter timing and write-backs.
// Assumes it is bound to exd_decode; quarters counted from reset.
`timescale 1ns/1ps
`default_nettype none
module exd_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire logic [13:0] pointer_two,
  input wire logic dm_rd_en,
  input wire logic dm_wr_en,
  input wire logic [13:0] dm_wr_addr,
  input wire logic ptr2_wr_en,
  input wire logic [13:0] ptr2_wr_data,
  input wire logic flag_wr_en,
  input wire logic pc_pop_stack,
  input wire logic nop_cycle,
  input wire logic std_pass,
  input wire logic ext_active
);
  ////////////////////////////////////////////////////////////////////
  logic [1:0] ph_ff;
  // Zero on the edge that takes a fetch word
  always_ff @(posedge clk_sys) ph_ff <= rst ? 2'h0 : ph_ff + 2'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  a_read_one_clk: assert property (dm_rd_en |=> !dm_rd_en)
    else $error("read strobe longer than one clock");
  a_read_in_q2: assert property (dm_rd_en |-> ph_ff == 2'h1)
    else $error("read strobe outside the second quarter");
  a_write_in_q4: assert property (dm_wr_en |-> ph_ff == 2'h3)
    else $error("write strobe outside the fourth quarter");
  a_flag_after_rd: assert property (flag_wr_en |-> $past(dm_rd_en, 2))
    else $error("flag write without a read two clocks before");
  a_pop_keeps_flags: assert property (pc_pop_stack |-> ptr2_wr_en && !flag_wr_en)
    else $error("return without pointer update or with flags");
  a_pop_then_nop: assert property (pc_pop_stack |-> ##2 nop_cycle [*3])
    else $error("no idle cycle after return");
  a_push_write: assert property (dm_wr_en && ptr2_wr_en |-> dm_wr_addr == $past(pointer_two) && ptr2_wr_data == $past(pointer_two) - 14'h1)
    else $error("push address or decrement wrong");
  a_fuse_gates_ext: assert property (pc_pop_stack |-> ext_active)
    else $error("extended return while extension off");
  a_std_not_idle: assert property (std_pass |-> !nop_cycle)
    else $error("standard and idle at once");
  // Main scenarios
  c_pop: cover property (pc_pop_stack);
  c_push: cover property (dm_wr_en && ptr2_wr_en);
  c_flag: cover property (flag_wr_en);
  c_idle: cover property (nop_cycle && ext_active);
endmodule
bind exd_decode exd_checker u_chk (.clk_sys(clk_sys), .rst(rst),
  .pointer_two(pointer_two), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
  .dm_wr_addr(dm_wr_addr), .ptr2_wr_en(ptr2_wr_en),
  .ptr2_wr_data(ptr2_wr_data), .flag_wr_en(flag_wr_en),
  .pc_pop_stack(pc_pop_stack), .nop_cycle(nop_cycle),
  .std_pass(std_pass), .ext_active(ext_active));
`default_nettype wire

//--- dv/exd_dmem_model.sv
// Data memory model answering the decoder's read strobe.
// Assumes the read is asked one clk_sys before the byte is used.
`timescale 1ns/1ps
`default_nettype none
module exd_dmem_model (
  // Clock
  input wire logic clk_sys,
  // Read request and answer
  input wire logic dm_rd_en,
  input wire logic [13:0] dm_rd_addr,
  output var logic [7:0] dm_rd_data
);
  ////////////////////////////////////////////////////////////////////
  initial dm_rd_data = 8'h00;
  // Byte one clock after the strobe; else flip so a late sample fails
  always @(posedge clk_sys) begin
    if (dm_rd_en) begin
      dm_rd_data <= dm_rd_addr[7:0] ^ 8'ha5;
    end else begin
      dm_rd_data <= ~dm_rd_data;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the extended instruction decoder.
// Assumes exd_decode with its bound checker and the memory model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fuse = 1'b0;
  logic fv = 1'b0;
  logic [15:0] fw = 16'h0000;
  logic [13:0] ptr = 14'h0000;
  logic [5:0] bank = 6'h00;
  logic [7:0] wv = 8'h00;
  wire logic rd_en, wr_en, pwr, pop, nop, std, lom, act;
  wire logic ww_en, fwr, fn, fz;
  wire logic [13:0] rd_a, wr_a, pwd, loa;
  wire logic [7:0] rd_d, wr_d, ww_d;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] rnd = 8'h54;
  logic [13:0] t_wa, t_pd, h_rd, h_loa;
  logic [7:0] t_wd, t_ww;
  logic t_we, t_pop, t_fw, t_fn, t_fz, h_nop, h_std, h_lom;
  ////////////////////////////////////////////////////////////////////
  always #10 clk_sys = ~clk_sys;
  exd_decode u_dut (.clk_sys(clk_sys), .rst(rst),
    .ext_set_enable_fuse(fuse), .fetch_valid(fv), .fetch_word(fw),
    .pointer_two(ptr), .bank_sel(bank), .w_reg(wv), .dm_rd_en(rd_en),
    .dm_rd_addr(rd_a), .dm_rd_data(rd_d), .dm_wr_en(wr_en),
    .dm_wr_addr(wr_a), .dm_wr_data(wr_d), .w_wr_en(ww_en),
    .w_wr_data(ww_d), .ptr2_wr_en(pwr), .ptr2_wr_data(pwd),
    .flag_wr_en(fwr), .flag_n(fn), .flag_z(fz),
    .pc_pop_stack(pop), .std_pass(std), .lit_ofs_mode(lom),
    .lit_ofs_addr(loa), .nop_cycle(nop), .ext_active(act));
  exd_dmem_model u_mem (.clk_sys(clk_sys), .dm_rd_en(rd_en),
    .dm_rd_addr(rd_a), .dm_rd_data(rd_d));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk_v(input string n, input logic [13:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_f(input string n, input logic e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  // One instruction cycle. Called in the time step of a Q4 edge, before
  // its updates, so the t_ values are the previous instruction's Q4
  // strobes; the second edge shows this instruction's Q2 outputs
  task automatic cyc(input logic [15:0] w, input logic [13:0] p);
    t_we = wr_en;
    t_wa = wr_en ? wr_a : 14'hxxxx;
    t_wd = wr_en ? wr_d : 8'hxx;
    t_pd = pwr ? pwd : 14'hxxxx;
    t_pop = pop;
    t_ww = ww_en ? ww_d : 8'hxx;
    t_fw = fwr;
    t_fn = fn;
    t_fz = fz;
    fw <= w;
    fv <= 1'b1;
    ptr <= p;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      if (i == 1) begin
        h_rd = rd_en ? rd_a : 14'hxxxx;
        h_nop = nop;
        h_std = std;
        h_lom = lom;
        h_loa = loa;
      end
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Run is under a thousand clocks; ten thousand means a hang
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [13:0] p, fd, ra;
    logic [7:0] k, f, xr;
    logic [6:0] zs, zd;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // Extension off: extended words go through as standard ones
    cyc(16'he8c5, 14'h0100);
    chk_f("ext_active", 1'b0, act);
    chk_f("std_pass", 1'b1, h_std);
    cyc(16'h2410, 14'h0100);
    chk_f("pop", 1'b0, t_pop);
    chk_f("lit_ofs", 1'b0, h_lom);
    fuse <= 1'b1;
    repeat (4) cyc(16'hf000, 14'h0100);
    chk_f("lone_tail_nop", 1'b1, h_nop);
    chk_f("ext_active", 1'b1, act);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      p = {rnd[5:0], lfsr(rnd)};
      rnd = lfsr(rnd);
      k = (i == 0) ? 8'h3f : {2'h0, rnd[5:0]};
      f = (i == 0) ? 8'h5f : {2'h0, rnd[5:0]};
      zs = rnd[6:0] ^ 7'h55;
      zd = rnd[7:1];
      fd = {p[1:0], rnd, rnd[3:0]};
      if (i == 0) p = 14'h3fff;
      bank <= p[13:8];
      wv <= ~rnd;
      cyc(16'he8c0 | {10'h0, k[5:0]}, p);
      cyc(16'hea11, p);
      chk_v("ptr_add", p + {8'h0, k[5:0]}, t_pd);
      chk_f("pop_add", 1'b1, t_pop);
      chk_f("nop_add", 1'b1, h_nop);
      cyc(16'he9c0 | {10'h0, k[5:0]}, p);
      chk_f("discard_wr", 1'b0, t_we);
      cyc(16'hf000, p);
      chk_v("ptr_sub", p - {8'h0, k[5:0]}, t_pd);
      chk_f("pop_sub", 1'b1, t_pop);
      chk_f("nop_sub", 1'b1, h_nop);
      cyc(16'hea00 | {8'h0, rnd}, p);
      cyc(16'h1b00 | {8'h0, f}, p);
      chk_v("push_addr", p, t_wa);
      chk_v("push_data", {6'h0, rnd}, {6'h0, t_wd});
      chk_v("push_ptr", p - 14'h1, t_pd);
      chk_v("xor_rd", {p[13:8], f}, h_rd);
      xr = f ^ 8'ha5 ^ ~rnd;
      cyc(16'h1800 | {8'h0, f}, p);
      chk_v("xor_wa", {p[13:8], f}, t_wa);
      chk_v("xor_wd", {6'h0, xr}, {6'h0, t_wd});
      chk_f("xor_flag", 1'b1, t_fw);
      chk_f("xor_n", xr[7], t_fn);
      chk_f("xor_z", xr == 8'h00, t_fz);
      ra = p + {6'h0, f};
      chk_v("lit_rd", ra, h_rd);
      xr = ra[7:0] ^ 8'ha5 ^ ~rnd;
      cyc(16'h2400 | {8'h0, f}, p);
      chk_f("xor_to_w", 1'b0, t_we);
      chk_v("xor_w", {6'h0, xr}, {6'h0, t_ww});
      chk_f("lit_mode", 1'b1, h_lom);
      chk_v("lit_addr", p + {6'h0, f}, h_loa);
      ra = (p + {7'h0, zs}) & 14'h0fff;
      cyc(16'heb00 | {9'h0, zs}, p);
      chk_f("nop_first", 1'b1, h_nop);
      cyc(16'hf000 | {4'h0, fd[11:0]}, p);
      chk_v("move_indexed_to_file_rd", ra, h_rd);
      cyc(16'heb80 | {9'h0, zs}, p);
      chk_v("move_indexed_to_file_wa", fd & 14'h0fff, t_wa);
      chk_v("move_indexed_to_file_wd", {6'h0, ra[7:0] ^ 8'ha5}, {6'h0, t_wd});
      cyc(16'hf000 | {9'h0, zd}, p);
      cyc(16'h0002, p);
      chk_v("move_indexed_to_indexed_wa", (p + {7'h0, zd}) & 14'h0fff, t_wa);
      cyc({7'h78, zs, fd[13:12]}, p);
      cyc(16'hf000 | {4'h0, fd[11:0]}, p);
      chk_v("long_rd", p + {7'h0, zs}, h_rd);
      cyc(16'hf000, p);
      chk_v("long_wa", fd, t_wa);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
